// ### core/fiber_link_lock_and_loopback_control.sv
// Frame timing, lock acquisition and loopback control of the fiber modem
`timescale 1ns/1ps

module fiber_link_lock_and_loopback_control
  import fiber_link_pkg::*;
#(
  parameter int unsigned POR_CYCLES   = POR_MIN_CYCLES,
  parameter int unsigned HS_PERIOD_A  = HS_PERIOD_00,
  parameter int unsigned HS_PERIOD_B  = HS_PERIOD_01,
  parameter int unsigned HS_PERIOD_C  = HS_PERIOD_10,
  parameter int unsigned HS_PERIOD_D  = HS_PERIOD_11
) (
  // Clock and resets
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 power_on_reset_n,
  // Mode and bandwidth straps
  input  wire logic                 link_mode_sel_bit0,
  input  wire logic                 link_mode_sel_bit1,
  input  wire logic                 link_mode_sel_bit2,
  input  wire logic                 handshake_bw_sel_lsb,
  input  wire logic                 handshake_bw_sel_msb,
  // User serial side
  input  wire logic                 txd,
  input  wire logic                 rts,
  input  wire logic                 dtr,
  input  wire logic                 ring_channel_in,
  output logic                      rxd,
  output logic                      cts,
  output logic                      dsr,
  output logic                      ring_channel_out,
  output logic                      lock_indicator_n,
  // Status
  output logic                      linkActive,
  output logic                      superCompress,
  output logic                      remoteLoopServing,
  // Link burst side
  input  wire logic                 rxValid,
  input  wire fiber_link_pkg::link_frame_t rxFrame,
  output logic                      txValid,
  output fiber_link_pkg::link_frame_t txFrame
);
  import fiber_link_pkg::*;

  top_state_t          st;
  top_state_t          next;
  pin_sample_t         pins;
  pin_sample_t         pin;
  mode_cfg_t           cfg;
  logic                coreRstN;
  logic [HS_CNT_W-1:0] hsPeriod;
  hs_bits_t            hsPub;
  logic                isLocked;
  logic                rxHit;
  logic                frameEnd;
  logic                servingNow;
  logic                activeRole;
  logic                randomRole;
  logic                shorten;
  logic                nextLocked;
  logic [2:0]          newHits;
  logic [2:0]          newMisses;
  sync_state_t         nextSync;
  frm_t                frameLen;
  frm_t                nextCnt;
  logic [1:0]          cf;
  link_frame_t         ownFrame;

  assign pins = '{porN: power_on_reset_n,
                  bw:   {handshake_bw_sel_msb, handshake_bw_sel_lsb},
                  mode: {link_mode_sel_bit2, link_mode_sel_bit1,
                         link_mode_sel_bit0},
                  hs:   '{rts: rts, dtr: dtr, ring: ring_channel_in},
                  txd:  txd};
  assign pin      = st.sync2;
  assign cfg      = decode_mode(pin.mode);
  assign coreRstN = rst_n & ~st.porHeld;

  always_comb begin
    unique case (pin.bw)
      BW_SUPER: hsPeriod = HS_CNT_W'(HS_PERIOD_A);
      BW_10K:   hsPeriod = HS_CNT_W'(HS_PERIOD_B);
      BW_5K:    hsPeriod = HS_CNT_W'(HS_PERIOD_C);
      BW_2K5:   hsPeriod = HS_CNT_W'(HS_PERIOD_D);
    endcase
  end

  handshake_pacer u_pacer (
    .clk       (clk),
    .rst_n     (coreRstN),
    .period    (hsPeriod),
    .sample    (pin.hs),
    .published (hsPub),
    .pending   ()
  );

  always_comb begin
    next       = st;
    next.sync1 = pins;
    next.sync2 = st.sync1;
    // Short glitches on the reset pin are ignored
    if (pin.porN) begin
      next.porCnt  = '0;
      next.porHeld = 1'b0;
    end else if (st.porCnt >= POR_CNT_W'(POR_CYCLES - 1)) begin
      next.porHeld = 1'b1;
    end else begin
      next.porCnt = st.porCnt + 1'b1;
    end

    isLocked = st.core.sync == SYNC_LOCKED;
    rxHit    = rxValid && st.core.cnt >= RX_START && st.core.cnt < RX_END;
    frameEnd = st.core.cnt == st.core.frameLast;
    nextCnt  = frameEnd ? '0 : st.core.cnt + 1'b1;
    next.core.cnt  = nextCnt;
    next.core.lfsr = {st.core.lfsr[14:0], ^(st.core.lfsr & LFSR_TAPS)};

    // Payload is latched in every mode but not shown in local loopback
    if (rxHit) begin
      next.core.hitSeen = 1'b1;
      next.core.hitPos  = st.core.cnt;
      next.core.rxLast  = rxFrame;
    end

    next.core.txdPrev = pin.txd;
    if (pin.txd != st.core.txdPrev && st.core.edges != '1) begin
      next.core.edges = st.core.edges + 1'b1;
    end

    // Echoing stops as soon as lock is lost, so stale requests die out
    servingNow = isLocked && cfg.loopMode != LOOP_LOCAL
                 && st.core.rxLast.loopReq;
    next.core.serving = servingNow;

    // A second shortening end would chase forever and never lock
    activeRole = cfg.lockMode == LOCK_ACTIVE
                 || (cfg.lockMode == LOCK_MEMORY && st.core.roleValid
                     && st.core.roleActive);
    randomRole = cfg.lockMode == LOCK_RANDOM
                 || (cfg.lockMode == LOCK_MEMORY && !st.core.roleValid);

    if (st.core.hitSeen) begin
      newHits   = (st.core.hits == LOCK_FRAMES) ? st.core.hits
                                                : st.core.hits + 1'b1;
      newMisses = '0;
    end else begin
      newHits   = '0;
      newMisses = (st.core.misses == LOSS_FRAMES) ? st.core.misses
                                                  : st.core.misses + 1'b1;
    end

    nextSync = st.core.sync;
    unique case (st.core.sync)
      SYNC_HUNT: begin
        if (st.core.hitSeen) nextSync = SYNC_ACQUIRE;
      end
      SYNC_ACQUIRE: begin
        if (!st.core.hitSeen) nextSync = SYNC_HUNT;
        else if (newHits == LOCK_FRAMES) nextSync = SYNC_LOCKED;
      end
      SYNC_LOCKED: begin
        if (newMisses == LOSS_FRAMES) nextSync = SYNC_HUNT;
      end
      default: nextSync = SYNC_HUNT;
    endcase
    nextLocked = nextSync == SYNC_LOCKED;

    // Drift ends keep the nominal cycle and wait for crystal skew
    shorten  = !nextLocked && (activeRole
               || (randomRole && st.core.lfsr[0]));
    frameLen = shorten ? SHORT_CYCLES : FRAME_CYCLES;
    if (isLocked && nextLocked && st.core.hitSeen) begin
      if (st.core.hitPos < RX_CENTER) begin
        frameLen = frameLen - 1'b1;
      end else if (st.core.hitPos > RX_CENTER) begin
        frameLen = frameLen + 1'b1;
      end
    end

    if (pin.bw != BW_SUPER) begin
      cf = CF_STANDARD;
    end else if (st.core.edges == '0) begin
      cf = CF_MAX;
    end else if (st.core.edges >= CF_BUSY_EDGES) begin
      cf = CF_STANDARD;
    end else begin
      cf = CF_MID;
    end

    ownFrame = '{data: pin.txd, hs: hsPub,
                 loopReq: cfg.loopMode == LOOP_REMOTE
                          && !st.core.serving,
                 loopEcho: 1'b0,
                 roleActive: st.core.roleValid && st.core.roleActive,
                 compression_factor: cf};
    if (st.core.serving) begin
      ownFrame.data     = st.core.rxLast.data;
      ownFrame.hs       = st.core.rxLast.hs;
      ownFrame.loopEcho = 1'b1;
    end

    next.core.txValid = frameEnd;
    if (frameEnd) begin
      next.core.txFrame       = ownFrame;
      next.core.superCompress = pin.bw == BW_SUPER;
      next.core.edges         = '0;
      next.core.hitSeen       = 1'b0;
      next.core.hits          = newHits;
      next.core.misses        = newMisses;
      next.core.sync          = nextSync;
      next.core.frameLast     = frameLen - 1'b1;
      if (nextLocked && !isLocked && cfg.lockMode == LOCK_MEMORY
          && !st.core.roleValid) begin
        next.core.roleValid  = 1'b1;
        next.core.roleActive = !st.core.rxLast.roleActive
                               && st.core.lfsr[1];
      end
    end

    next.core.linkActive = nextCnt < TX_WIN
                           || (nextCnt >= RX_START && nextCnt < RX_END);

    if (cfg.loopMode == LOOP_LOCAL) begin
      next.core.rxd     = pin.txd;
      next.core.cts     = pin.hs.rts;
      next.core.dsr     = pin.hs.dtr;
      next.core.ringOut = pin.hs.ring;
    end else if (!isLocked) begin
      next.core.rxd     = 1'b0;
      next.core.cts     = 1'b1;
      next.core.dsr     = 1'b1;
      next.core.ringOut = 1'b0;
    end else begin
      next.core.rxd     = st.core.rxLast.data;
      next.core.cts     = st.core.rxLast.hs.rts;
      next.core.dsr     = st.core.rxLast.hs.dtr;
      next.core.ringOut = st.core.rxLast.hs.ring;
    end
    next.core.lockN = !isLocked;

    // Role memory is lost with the core reset, so arbitration restarts
    if (st.porHeld) begin
      next.core = CORE_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= TOP_RESET;
    end else begin
      st <= next;
    end
  end

  assign rxd               = st.core.rxd;
  assign cts               = st.core.cts;
  assign dsr               = st.core.dsr;
  assign ring_channel_out  = st.core.ringOut;
  assign lock_indicator_n  = st.core.lockN;
  assign linkActive        = st.core.linkActive;
  assign superCompress     = st.core.superCompress;
  assign remoteLoopServing = st.core.serving;
  assign txValid           = st.core.txValid;
  assign txFrame           = st.core.txFrame;

  localparam int GAP_MIN = 994;
  localparam int GAP_MAX = 1001;
  logic [FRM_W:0] gap;
  always_ff @(posedge clk) begin
    if (!coreRstN) begin
      gap <= '0;
    end else if (txValid) begin
      gap <= 11'h001;
    end else if (gap != '0 && gap != '1) begin
      gap <= gap + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!coreRstN);

  a_unlocked_forced: assert property (
    !isLocked && cfg.loopMode != LOOP_LOCAL |=> !rxd && cts && dsr)
    else $error("outputs not forced while unlocked");
  a_local_loop_path: assert property (
    cfg.loopMode == LOOP_LOCAL && !st.porHeld |=> rxd == $past(pin.txd)
                                   && cts == $past(pin.hs.rts))
    else $error("local loopback path broken");
  a_local_over_remote: assert property (
    cfg.loopMode == LOOP_LOCAL |=> !remoteLoopServing)
    else $error("remote echo during local loopback");
  a_own_req_muted: assert property (
    txValid && $past(remoteLoopServing) |-> !txFrame.loopReq
                                            && txFrame.loopEcho)
    else $error("own loopback request while echoing");
  a_cf_standard: assert property (
    txValid && !superCompress |-> txFrame.compression_factor == CF_STANDARD)
    else $error("extra compression outside super mode");
  a_super_select: assert property (
    txValid |-> superCompress == ($past(pin.bw) == BW_SUPER))
    else $error("super mode does not follow selects");
  a_frame_length: assert property (
    txValid && gap != 0 |-> gap >= GAP_MIN && gap <= GAP_MAX)
    else $error("frame length out of range");
  a_frame_spacing: assert property (
    txValid |=> !txValid [*8])
    else $error("bursts too close");
  a_tx_in_window: assert property (
    txValid |-> linkActive)
    else $error("burst outside active window");
  a_lock_entry: assert property (
    $fell(lock_indicator_n) |-> st.core.hits == LOCK_FRAMES)
    else $error("lock without enough aligned frames");
  a_por_clears: assert property (@(posedge clk) disable iff (!rst_n)
    st.porHeld |=> lock_indicator_n && !txValid)
    else $error("long reset pulse did not reset core");

  c_locked: cover property ($fell(lock_indicator_n));
  c_serving: cover property (remoteLoopServing ##1 txValid);
  c_super_max: cover property (
    txValid && txFrame.compression_factor == CF_MAX);
  c_local_locked: cover property (
    cfg.loopMode == LOOP_LOCAL && !lock_indicator_n);

endmodule : fiber_link_lock_and_loopback_control

// ### core/fiber_link_pkg.sv
// Constants, carrier types and mode decode for the fiber link lock control
package fiber_link_pkg;

  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned POR_MIN_MS     = 100;
  localparam int unsigned POR_MIN_CYCLES = (CLK_HZ / 1000) * POR_MIN_MS;
  localparam int unsigned HS_HZ_00       = 600;
  localparam int unsigned HS_HZ_01       = 10_000;
  localparam int unsigned HS_HZ_10       = 5_000;
  localparam int unsigned HS_HZ_11       = 2_500;
  // Least spacing between handshake updates, rounded up to whole cycles
  localparam int unsigned HS_PERIOD_00 = (CLK_HZ + HS_HZ_00 - 1) / HS_HZ_00;
  localparam int unsigned HS_PERIOD_01 = (CLK_HZ + HS_HZ_01 - 1) / HS_HZ_01;
  localparam int unsigned HS_PERIOD_10 = (CLK_HZ + HS_HZ_10 - 1) / HS_HZ_10;
  localparam int unsigned HS_PERIOD_11 = (CLK_HZ + HS_HZ_11 - 1) / HS_HZ_11;

  localparam int POR_CNT_W = 24;
  localparam int HS_CNT_W  = 18;
  localparam int FRM_W     = 10;
  typedef logic [FRM_W-1:0] frm_t;

  localparam frm_t        FRAME_CYCLES     = 10'h3E8;
  localparam int unsigned SHORTEN_PERMILLE = 5;
  localparam frm_t        SHORT_CYCLES     = frm_t'(FRAME_CYCLES -
                            FRAME_CYCLES * SHORTEN_PERMILLE / 1000);
  localparam frm_t        TX_WIN           = 10'h028;
  localparam frm_t        RX_START         = 10'h1F4;
  localparam frm_t        RX_END           = 10'h258;
  localparam frm_t        RX_CENTER        = 10'h226;
  localparam logic [2:0]  LOCK_FRAMES      = 3'h4;
  localparam logic [2:0]  LOSS_FRAMES      = 3'h4;
  localparam logic [1:0]  CF_STANDARD      = 2'h1;
  localparam logic [1:0]  CF_MID           = 2'h2;
  localparam logic [1:0]  CF_MAX           = 2'h3;
  localparam logic [3:0]  CF_BUSY_EDGES    = 4'h4;
  localparam logic [1:0]  BW_SUPER         = 2'h0;
  localparam logic [1:0]  BW_10K           = 2'h1;
  localparam logic [1:0]  BW_5K            = 2'h2;
  localparam logic [1:0]  BW_2K5           = 2'h3;
  localparam logic [2:0]  MODE_DRIFT       = 3'h0;
  localparam logic [2:0]  MODE_ACTIVE      = 3'h1;
  localparam logic [2:0]  MODE_MEMORY      = 3'h2;
  localparam logic [2:0]  MODE_LOCAL       = 3'h5;
  localparam logic [2:0]  MODE_REMOTE      = 3'h6;
  localparam logic [2:0]  MODE_RANDOM      = 3'h7;
  localparam logic [15:0] LFSR_SEED        = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS        = 16'hB400;

  typedef enum logic [1:0] {
    LOCK_DRIFT, LOCK_ACTIVE, LOCK_MEMORY, LOCK_RANDOM
  } lock_mode_t;
  typedef enum logic [1:0] {LOOP_NONE, LOOP_LOCAL, LOOP_REMOTE} loop_mode_t;
  typedef enum logic [1:0] {
    SYNC_HUNT = 2'h0, SYNC_ACQUIRE = 2'h1, SYNC_LOCKED = 2'h3
  } sync_state_t;

  typedef struct packed {logic rts; logic dtr; logic ring;} hs_bits_t;
  typedef struct packed {
    logic       data;
    hs_bits_t   hs;
    logic       loopReq;
    logic       loopEcho;
    logic       roleActive;
    logic [1:0] compression_factor;
  } link_frame_t;
  typedef struct packed {
    logic porN; logic [1:0] bw; logic [2:0] mode; hs_bits_t hs; logic txd;
  } pin_sample_t;
  typedef struct packed {
    lock_mode_t lockMode; loop_mode_t loopMode;
  } mode_cfg_t;
  typedef struct packed {
    logic [HS_CNT_W-1:0] cnt; hs_bits_t published; logic pending;
  } pacer_state_t;
  typedef struct packed {
    sync_state_t sync;
    frm_t        cnt;
    frm_t        frameLast;
    logic        hitSeen;
    frm_t        hitPos;
    logic [2:0]  hits;
    logic [2:0]  misses;
    logic [15:0] lfsr;
    logic        roleValid;
    logic        roleActive;
    link_frame_t rxLast;
    logic [3:0]  edges;
    logic        txdPrev;
    logic        rxd;
    logic        cts;
    logic        dsr;
    logic        ringOut;
    logic        lockN;
    logic        linkActive;
    logic        superCompress;
    logic        serving;
    logic        txValid;
    link_frame_t txFrame;
  } core_t;
  typedef struct packed {
    pin_sample_t          sync1;
    pin_sample_t          sync2;
    logic [POR_CNT_W-1:0] porCnt;
    logic                 porHeld;
    core_t                core;
  } top_state_t;

  localparam core_t CORE_RESET = '{sync: SYNC_HUNT,
    frameLast: FRAME_CYCLES - 10'h001, lfsr: LFSR_SEED, cts: 1'b1,
    dsr: 1'b1, lockN: 1'b1, default: '0};
  localparam top_state_t TOP_RESET = '{core: CORE_RESET, default: '0};

  function automatic mode_cfg_t decode_mode(input logic [2:0] m);
    unique case (m)
      MODE_DRIFT:  return '{lockMode: LOCK_DRIFT,  loopMode: LOOP_NONE};
      MODE_ACTIVE: return '{lockMode: LOCK_ACTIVE, loopMode: LOOP_NONE};
      MODE_MEMORY: return '{lockMode: LOCK_MEMORY, loopMode: LOOP_NONE};
      MODE_LOCAL:  return '{lockMode: LOCK_RANDOM, loopMode: LOOP_LOCAL};
      MODE_REMOTE: return '{lockMode: LOCK_RANDOM, loopMode: LOOP_REMOTE};
      MODE_RANDOM: return '{lockMode: LOCK_RANDOM, loopMode: LOOP_NONE};
      // Undefined codes fall back to the quietest mode
      default:     return '{lockMode: LOCK_DRIFT,  loopMode: LOOP_NONE};
    endcase
  endfunction : decode_mode

endpackage : fiber_link_pkg

// ### core/handshake_pacer.sv
// Rate limiter that defers handshake updates to the selected bandwidth
`timescale 1ns/1ps
module handshake_pacer
  import fiber_link_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Pacing
  input  wire logic [HS_CNT_W-1:0]   period,
  input  wire fiber_link_pkg::hs_bits_t sample,
  output fiber_link_pkg::hs_bits_t   published,
  output logic                       pending
);
  pacer_state_t st;
  pacer_state_t next;

  always_comb begin
    next = st;
    if (st.cnt != '0) begin
      next.cnt = st.cnt - 1'b1;
    end
    // A change inside the guard time waits; the newest level goes out later
    next.pending = (sample != st.published);
    if (st.cnt == '0 && sample != st.published) begin
      next.published = sample;
      next.cnt       = period - 1'b1;
      next.pending   = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next;
    end
  end

  assign published = st.published;
  assign pending   = st.pending;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_pace_hold: assert property (
    st.cnt > 1 |=> published == $past(published))
    else $error("handshake update inside guard time");
  a_pace_reload: assert property (
    $changed(published) |-> st.cnt == $past(period) - 1)
    else $error("guard time not reloaded on update");
  c_pace_defer: cover property (pending ##1 !pending);

endmodule : handshake_pacer

// ### testbench/far_modem_model.sv
// Far-end modem model answering each of our bursts in our receive window
`timescale 1ns/1ps
module far_modem_model (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Link bursts
  input  wire logic                        txValid,
  input  wire fiber_link_pkg::link_frame_t txFrame,
  output logic                             rxValid,
  output fiber_link_pkg::link_frame_t      rxFrame,
  // Control from the bench
  input  wire logic                        enable,
  input  wire fiber_link_pkg::link_frame_t payload
);
  import fiber_link_pkg::*;
  int unsigned delay;
  // Idle frame lines toggle so a stale sample never looks like a burst
  always_ff @(posedge clk) begin
    rxValid <= 1'b0;
    rxFrame <= ~rxFrame;
    if (!rst_n) begin
      delay   <= 0;
      rxFrame <= '0;
    end else if (txValid && enable) begin
      delay <= 550;
    end else if (delay != 0) begin
      delay <= delay - 1;
      if (delay == 1) begin
        rxValid <= 1'b1;
        rxFrame <= payload;
        if (txFrame.loopReq) begin
          rxFrame <= '{data: txFrame.data, hs: txFrame.hs,
                       loopEcho: 1'b1, default: '0};
        end
      end
    end
  end
endmodule : far_modem_model

// ### testbench/testbench.sv
// Self-checking bench for the fiber link lock and loopback control
`timescale 1ns/1ps
module testbench;
  import fiber_link_pkg::*;
  logic        clk, rst_n, porN, txd, rts, dtr, ringIn, en;
  logic        rxd, cts, dsr, ringOut, lockN, linkActive, superCompress;
  logic        serving, rxValid, txValid;
  logic [2:0]  mode;
  logic [1:0]  bw;
  link_frame_t rxFrame, txFrame, payload;
  int          miscompares, totalChecks, lastGap;

  fiber_link_lock_and_loopback_control #(.POR_CYCLES(20), .HS_PERIOD_A(40),
    .HS_PERIOD_B(10), .HS_PERIOD_C(20), .HS_PERIOD_D(30)) dut_u (
    .clk(clk), .rst_n(rst_n), .power_on_reset_n(porN),
    .link_mode_sel_bit0(mode[0]), .link_mode_sel_bit1(mode[1]),
    .link_mode_sel_bit2(mode[2]), .handshake_bw_sel_lsb(bw[0]),
    .handshake_bw_sel_msb(bw[1]), .txd(txd), .rts(rts), .dtr(dtr),
    .ring_channel_in(ringIn), .rxd(rxd), .cts(cts), .dsr(dsr),
    .ring_channel_out(ringOut), .lock_indicator_n(lockN),
    .linkActive(linkActive), .superCompress(superCompress),
    .remoteLoopServing(serving), .rxValid(rxValid), .rxFrame(rxFrame),
    .txValid(txValid), .txFrame(txFrame));

  far_modem_model far_u (.clk(clk), .rst_n(rst_n), .txValid(txValid),
    .txFrame(txFrame), .rxValid(rxValid), .rxFrame(rxFrame), .enable(en),
    .payload(payload));

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    if (miscompares == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // Waits past the next burst start; a missing burst ends the run
  task automatic wait_tx(int frames = 1);
    int n;
    repeat (frames) begin
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (txValid !== 1'b1 && n < 1100);
      lastGap = n;
      if (n >= 1100) begin
        miscompares++;
        conclude();
      end
    end
  endtask : wait_tx

  task automatic sc_lock();
    check("unlocked outputs", {lockN, rxd, cts, dsr}, 4'hB);
    @(posedge clk);
    en <= 1'b1;
    payload <= '{data: 1'b1, hs: '{rts: 1'b0, dtr: 1'b1, ring: 1'b1},
                 default: '0};
    rts <= 1'b1;
    @(posedge clk);
    rts <= 1'b0;
    dtr <= 1'b1;
    for (int i = 0; i < 12 && lockN !== 1'b0; i++) wait_tx();
    wait_tx(2);
    check("locked outputs", {lockN, rxd, cts, dsr}, 4'h5);
    check("ring out", {3'h0, ringOut}, 4'h1);
    check("paced handshakes", {1'b0, txFrame.hs}, 4'h2);
  endtask : sc_lock

  task automatic sc_window();
    int gap [3] = '{100, 450, 100};
    logic exp [3] = '{1'b0, 1'b1, 1'b0};
    wait_tx();
    check("active at burst", {3'h0, linkActive}, 4'h1);
    foreach (gap[i]) begin
      repeat (gap[i]) @(posedge clk);
      #1;
      check("active window", {3'h0, linkActive}, {3'h0, exp[i]});
    end
  endtask : sc_window

  task automatic sc_bw();
    for (int b = 3; b >= 0; b--) begin
      @(posedge clk);
      bw <= 2'(b);
      wait_tx(3);
      check("super compress", {superCompress, 1'b0,
        txFrame.compression_factor}, {b == 0, 1'b0,
        b == 0 ? CF_MAX : CF_STANDARD});
    end
    repeat (2) begin
      @(posedge clk);
      txd <= ~txd;
    end
    wait_tx();
    check("mid compress", {2'h0, txFrame.compression_factor},
      {2'h0, CF_MID});
    repeat (4) begin
      @(posedge clk);
      txd <= ~txd;
    end
    wait_tx();
    check("busy compress", {2'h0, txFrame.compression_factor},
      {2'h0, CF_STANDARD});
  endtask : sc_bw

  task automatic sc_remote();
    @(posedge clk);
    mode <= MODE_REMOTE;
    wait_tx(3);
    check("remote request", {txFrame.loopReq, txFrame.loopEcho, serving,
      rxd}, 4'h9);
    @(posedge clk);
    mode <= MODE_RANDOM;
    payload <= '{loopReq: 1'b1, default: '0};
    wait_tx(3);
    check("serving", {txFrame.loopReq, txFrame.loopEcho, serving,
      rxd}, 4'h6);
    @(posedge clk);
    mode <= MODE_REMOTE;
    wait_tx(2);
    check("own request held", {txFrame.loopReq, txFrame.loopEcho, serving,
      rxd}, 4'h6);
  endtask : sc_remote

  task automatic sc_local();
    @(posedge clk);
    mode <= MODE_LOCAL;
    txd <= 1'b0;
    ringIn <= 1'b1;
    wait_tx(3);
    check("local loop", {rxd, cts, dsr, ringOut}, 4'h3);
    check("local wins", {2'h0, serving, lockN}, 4'h0);
    @(posedge clk);
    txd <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check("local data", {3'h0, rxd}, 4'h1);
  endtask : sc_local

  task automatic sc_por();
    @(posedge clk);
    mode <= MODE_RANDOM;
    porN <= 1'b0;
    repeat (10) @(posedge clk);
    porN <= 1'b1;
    wait_tx(2);
    check("short pulse", {3'h0, lockN}, 4'h0);
    @(posedge clk);
    porN <= 1'b0;
    repeat (40) @(posedge clk);
    #1;
    check("power on reset", {lockN, rxd, cts, dsr}, 4'hB);
  endtask : sc_por

  // Partner silent, so frame lengths show the unlocked cycle of the active and drift modes; memory mode then locks with the partner on
  task automatic sc_modes();
    @(posedge clk);
    en <= 1'b0;
    mode <= MODE_ACTIVE;
    porN <= 1'b1;
    wait_tx(2);
    check("active frame", 16'(lastGap), 16'(SHORT_CYCLES));
    @(posedge clk);
    mode <= MODE_DRIFT;
    wait_tx(2);
    check("drift frame", 16'(lastGap), 16'(FRAME_CYCLES));
    @(posedge clk);
    mode <= MODE_MEMORY;
    en <= 1'b1;
    for (int i = 0; i < 12 && lockN !== 1'b0; i++) wait_tx();
    check("memory lock", {3'h0, lockN}, 4'h0);
  endtask : sc_modes

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    porN = 1'b1;
    mode = MODE_RANDOM;
    bw = BW_10K;
    {txd, rts, dtr, ringIn, en} = 5'h10;
    payload = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    sc_lock();
    sc_window();
    sc_bw();
    sc_remote();
    sc_local();
    sc_por();
    sc_modes();
    conclude();
  end
endmodule : testbench
